// *** design/tes_sequencer.sv ***
// Trigger and exposure sequencer with an APB register slave.
// Assumes the trigger line is synchronous to clk_in and one clock domain.
`timescale 1ns/1ps
module tes_sequencer #(
  // Clock cycles in one microsecond of the exposure and delay time base.
  parameter int unsigned US_CYCLES = tes_pkg::CYC_PER_US
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic external_fire_line_in,
  output logic exposure_active_out,
  output logic frame_start_out,
  output logic trigger_wait_out
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_DELAY = 5'b00010,
    ST_EXPOSE = 5'b00100,
    ST_LEVEL = 5'b01000,
    ST_GAP = 5'b10000
  } tes_state_t;

  typedef struct packed {
    tes_state_t state;
    logic sync_sel;
    logic origin_sel;
    logic [1:0] seq_sel;
    logic pol_sel;
    logic policy_sel;
    logic [23:0] exposure_us;
    logic [20:0] delay_us;
    logic [7:0] bulk_total;
    logic [23:0] pace_us;
    logic fire_pend;
    logic line_d;
    logic [23:0] us_cnt;
    logic [7:0] frames_left;
    logic [15:0] gap_cnt;
    logic [31:0] frame_cnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic expo;
    logic fstart;
    logic twait;
  } tes_st_t;

  tes_st_t st_r;
  tes_st_t st_nxt;
  logic tick;
  logic tick_restart;

  // Clamps a requested exposure into the supported range.
  function automatic logic [23:0] clamp_exposure(input logic [31:0] v);
    if (v < 32'(tes_pkg::EXPOSURE_MIN_US)) begin
      return tes_pkg::EXPOSURE_MIN_US;
    end else if (v > 32'(tes_pkg::EXPOSURE_MAX_US)) begin
      return tes_pkg::EXPOSURE_MAX_US;
    end
    return v[23:0];
  endfunction

  // Microsecond time base, realigned whenever a timed phase begins.
  tes_us_tick #(
    .DIV(US_CYCLES)
  ) u_tick (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .restart_in(tick_restart),
    .tick_out(tick)
  );

  logic hw_edge;
  logic line_act;
  logic trig_hit;
  logic [23:0] expo_len;
  logic apb_acc;
  logic apb_wr;
  logic [23:0] gap_us;

  // Trigger qualification and exposure length selection.
  always_comb begin
    line_act = external_fire_line_in ^ st_r.pol_sel;
    hw_edge = line_act & ~(st_r.line_d ^ st_r.pol_sel);
    trig_hit = st_r.origin_sel ? st_r.fire_pend : hw_edge;
    expo_len = st_r.policy_sel ? clamp_exposure(32'(st_r.pace_us))
                               : st_r.exposure_us;
    gap_us = (st_r.pace_us > expo_len) ? st_r.pace_us - expo_len
                                       : 24'h000000;
    apb_acc = psel_in & penable_in & ~st_r.pready;
    apb_wr = apb_acc & pwrite_in;
  end

  // Next-state logic: registers, APB and the exposure sequencer.
  always_comb begin
    st_nxt = st_r;
    st_nxt.line_d = external_fire_line_in;
    st_nxt.pready = apb_acc;
    st_nxt.pslverr = 1'b0;
    st_nxt.fstart = 1'b0;
    tick_restart = 1'b0;
    // Register writes and reads, answered one cycle after access starts.
    if (apb_wr) begin
      unique case (paddr_in)
        tes_pkg::OFS_CTRL: begin
          st_nxt.sync_sel = pwdata_in[tes_pkg::CTRL_SYNC_BIT];
          st_nxt.origin_sel = pwdata_in[tes_pkg::CTRL_ORIGIN_BIT];
          st_nxt.seq_sel = pwdata_in[tes_pkg::CTRL_SEQ_LSB +: 2];
          st_nxt.pol_sel = pwdata_in[tes_pkg::CTRL_POL_BIT];
          st_nxt.policy_sel = pwdata_in[tes_pkg::CTRL_POLICY_BIT];
        end
        tes_pkg::OFS_EXPOSURE: begin
          st_nxt.exposure_us = clamp_exposure(pwdata_in);
        end
        tes_pkg::OFS_DELAY: begin
          st_nxt.delay_us = (pwdata_in > 32'(tes_pkg::DELAY_MAX_US)) ?
            tes_pkg::DELAY_MAX_US : pwdata_in[20:0];
        end
        tes_pkg::OFS_BULK: begin
          st_nxt.bulk_total = pwdata_in[7:0];
        end
        tes_pkg::OFS_PACE: begin
          st_nxt.pace_us = clamp_exposure(pwdata_in);
        end
        tes_pkg::OFS_FIRE: begin
          // Taken below, and only while a trigger is awaited.
        end
        tes_pkg::OFS_STATUS: begin
        end
        default: begin
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end else if (apb_acc) begin
      unique case (paddr_in)
        tes_pkg::OFS_CTRL: begin
          st_nxt.prdata = {26'h0, st_r.policy_sel, st_r.pol_sel,
                           st_r.seq_sel, st_r.origin_sel, st_r.sync_sel};
        end
        tes_pkg::OFS_EXPOSURE: st_nxt.prdata = {8'h00, st_r.exposure_us};
        tes_pkg::OFS_DELAY: st_nxt.prdata = {11'h000, st_r.delay_us};
        tes_pkg::OFS_BULK: st_nxt.prdata = {24'h000000, st_r.bulk_total};
        tes_pkg::OFS_PACE: st_nxt.prdata = {8'h00, st_r.pace_us};
        tes_pkg::OFS_FIRE: st_nxt.prdata = 32'h0000_0000;
        tes_pkg::OFS_STATUS: st_nxt.prdata = st_r.frame_cnt;
        default: begin
          st_nxt.prdata = 32'h0000_0000;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
    // Exposure sequencer.
    unique case (st_r.state)
      ST_IDLE: begin
        // Free run: start the next frame at once, whatever the sequence.
        if (!st_r.sync_sel) begin
          st_nxt.state = ST_EXPOSE;
          st_nxt.us_cnt = expo_len;
          st_nxt.frames_left = 8'h00;
          st_nxt.expo = 1'b1;
          st_nxt.fstart = 1'b1;
          tick_restart = 1'b1;
        end else if (trig_hit) begin
          // A pending host fire command is consumed here; commands
          // written while busy are never latched.
          st_nxt.fire_pend = 1'b0;
          st_nxt.frames_left = (st_r.seq_sel == tes_pkg::SEQ_BULK) ?
            st_r.bulk_total : 8'h00;
          tick_restart = 1'b1;
          if (!st_r.origin_sel && st_r.delay_us != 21'h0) begin
            st_nxt.state = ST_DELAY;
            st_nxt.us_cnt = {3'h0, st_r.delay_us};
          end else if (st_r.seq_sel == tes_pkg::SEQ_LEVEL) begin
            st_nxt.state = ST_LEVEL;
            st_nxt.expo = 1'b1;
            st_nxt.fstart = 1'b1;
          end else begin
            st_nxt.state = ST_EXPOSE;
            st_nxt.us_cnt = expo_len;
            st_nxt.expo = 1'b1;
            st_nxt.fstart = 1'b1;
          end
        end
      end
      ST_DELAY: begin
        if (tick) begin
          st_nxt.us_cnt = st_r.us_cnt - 24'h000001;
        end
        if (tick && st_r.us_cnt == 24'h000001) begin
          tick_restart = 1'b1;
          st_nxt.expo = 1'b1;
          st_nxt.fstart = 1'b1;
          if (st_r.seq_sel == tes_pkg::SEQ_LEVEL) begin
            st_nxt.state = ST_LEVEL;
          end else begin
            st_nxt.state = ST_EXPOSE;
            st_nxt.us_cnt = expo_len;
          end
        end
      end
      ST_LEVEL: begin
        if (!line_act) begin
          st_nxt.state = ST_IDLE;
          st_nxt.expo = 1'b0;
          st_nxt.frame_cnt = st_r.frame_cnt + 32'h1;
        end
      end
      ST_EXPOSE: begin
        if (tick) begin
          st_nxt.us_cnt = st_r.us_cnt - 24'h000001;
        end
        if (tick && st_r.us_cnt == 24'h000001) begin
          st_nxt.expo = 1'b0;
          st_nxt.frame_cnt = st_r.frame_cnt + 32'h1;
          st_nxt.gap_cnt = 16'(tes_pkg::FRAME_GAP_US * US_CYCLES);
          st_nxt.us_cnt = gap_us;
          st_nxt.state = ST_GAP;
          tick_restart = 1'b1;
        end
      end
      ST_GAP: begin
        // Holds the frame gap, and in free run the frame period; triggers are not looked at here.
        if (st_r.gap_cnt != 16'h0000) begin
          st_nxt.gap_cnt = st_r.gap_cnt - 16'h0001;
        end
        if (tick && st_r.us_cnt != 24'h000000 && !st_r.sync_sel) begin
          st_nxt.us_cnt = st_r.us_cnt - 24'h000001;
        end
        if (st_r.gap_cnt == 16'h0000 &&
            (st_r.sync_sel || st_r.us_cnt == 24'h000000)) begin
          if (st_r.sync_sel && st_r.frames_left > 8'h01) begin
            st_nxt.frames_left = st_r.frames_left - 8'h01;
            st_nxt.state = ST_EXPOSE;
            st_nxt.us_cnt = expo_len;
            st_nxt.expo = 1'b1;
            st_nxt.fstart = 1'b1;
            tick_restart = 1'b1;
          end else begin
            st_nxt.state = ST_IDLE;
          end
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
        st_nxt.expo = 1'b0;
      end
    endcase
    // A host fire command is latched only while a trigger is awaited.
    if (apb_wr && paddr_in == tes_pkg::OFS_FIRE &&
        st_r.state == ST_IDLE && st_r.sync_sel && st_r.origin_sel &&
        !st_r.fire_pend) begin
      st_nxt.fire_pend = 1'b1;
    end
    st_nxt.twait = st_r.sync_sel && (st_nxt.state == ST_IDLE);
  end

  // Registers the state.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
      st_r.state <= ST_IDLE;
      st_r.exposure_us <= tes_pkg::EXPOSURE_RST_US;
      st_r.bulk_total <= tes_pkg::BULK_RST;
      st_r.pace_us <= tes_pkg::PACE_RST_US;
      st_r.line_d <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata_out = st_r.prdata;
  assign pready_out = st_r.pready;
  assign pslverr_out = st_r.pslverr;
  assign exposure_active_out = st_r.expo;
  assign frame_start_out = st_r.fstart;
  assign trigger_wait_out = st_r.twait;

endmodule // tes_sequencer

// *** design/tes_us_tick.sv ***
// Microsecond tick generator for the trigger and exposure sequencer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tes_us_tick #(
  parameter int unsigned DIV = tes_pkg::CYC_PER_US
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic restart_in,
  output logic tick_out
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tes_tick_st_t;

  tes_tick_st_t st_r;
  tes_tick_st_t st_nxt;

  // Counts DIV cycles and pulses once; restart aligns to a new interval.
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (restart_in) begin
      st_nxt.cnt = 16'h0000;
    end else if (st_r.cnt == 16'(DIV - 1)) begin
      st_nxt.cnt = 16'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
    end
  end

  // Registers the state.
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;

endmodule // tes_us_tick

// *** include/tes_pkg.sv ***
// Package for the trigger and exposure sequencer: register map, fields,
// reset values and timing counts.
// Assumes a 250 MHz clock and an APB slave with 32-bit data.
package tes_pkg;

  // Clock rate and microsecond conversion.
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CYC_PER_US = CLK_MHZ;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EXPOSURE = 8'h04;
  localparam logic [7:0] OFS_DELAY = 8'h08;
  localparam logic [7:0] OFS_BULK = 8'h0c;
  localparam logic [7:0] OFS_PACE = 8'h10;
  localparam logic [7:0] OFS_FIRE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // Control register field positions.
  localparam int unsigned CTRL_SYNC_BIT = 0;
  localparam int unsigned CTRL_ORIGIN_BIT = 1;
  localparam int unsigned CTRL_SEQ_LSB = 2;
  localparam int unsigned CTRL_POL_BIT = 4;
  localparam int unsigned CTRL_POLICY_BIT = 5;

  // Sequence encodings.
  localparam logic [1:0] SEQ_EDGE = 2'h0;
  localparam logic [1:0] SEQ_LEVEL = 2'h1;
  localparam logic [1:0] SEQ_BULK = 2'h2;

  // Limits and reset values, in microseconds or frames.
  localparam logic [23:0] EXPOSURE_MIN_US = 24'h00001e;
  localparam logic [23:0] EXPOSURE_MAX_US = 24'hf42400;
  localparam logic [23:0] EXPOSURE_RST_US = 24'h001388;
  localparam logic [20:0] DELAY_MAX_US = 21'h1e8480;
  localparam logic [7:0] BULK_RST = 8'h00;
  localparam logic [23:0] PACE_RST_US = 24'h001388;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Gap between bulk frames, in microseconds.
  localparam int unsigned FRAME_GAP_US = 1;
  localparam int unsigned FRAME_GAP_CYC = FRAME_GAP_US * CYC_PER_US;

endpackage

// *** testbench/tes_sequencer_checker.sv ***
// Checker for the trigger and exposure sequencer top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module tes_sequencer_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic external_fire_line_in,
  input wire logic exposure_active_out,
  input wire logic frame_start_out,
  input wire logic trigger_wait_out
);
  // All checks share the one clock and its reset.
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  chk_ready_next:
    assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready late");
  chk_ready_pulse:
    assert property (pready_out |=> !pready_out)
    else $error("pready held");
  chk_ready_cause:
    assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("pready unasked");
  chk_err_ready:
    assert property (pslverr_out |-> pready_out)
    else $error("pslverr alone");
  chk_start_pulse:
    assert property (frame_start_out |=> !frame_start_out)
    else $error("frame start held");
  chk_start_expose:
    assert property (frame_start_out |-> exposure_active_out)
    else $error("start without exposure");
  chk_rise_start:
    assert property ($rose(exposure_active_out) |-> frame_start_out)
    else $error("exposure without start");
  chk_wait_idle:
    assert property (trigger_wait_out |-> !exposure_active_out)
    else $error("waiting while exposing");
endmodule // tes_sequencer_checker

bind tes_sequencer tes_sequencer_checker tes_sequencer_checker_inst (
  .clk_in(clk_in),
  .sys_rst_in(sys_rst_in),
  .psel_in(psel_in),
  .penable_in(penable_in),
  .pwrite_in(pwrite_in),
  .paddr_in(paddr_in),
  .pwdata_in(pwdata_in),
  .prdata_out(prdata_out),
  .pready_out(pready_out),
  .pslverr_out(pslverr_out),
  .external_fire_line_in(external_fire_line_in),
  .exposure_active_out(exposure_active_out),
  .frame_start_out(frame_start_out),
  .trigger_wait_out(trigger_wait_out)
);

// *** testbench/tes_trig_src.sv ***
// External trigger source model driving the hardware fire line.
// Assumes the line is changed in step with the sequencer clock.
`timescale 1ns/1ps
module tes_trig_src (
  input wire logic clk_in,
  output logic line_out
);
  logic idle_lvl;
  // The line rests at its idle level until a pulse is asked for.
  initial begin
    idle_lvl = 1'b0;
    line_out = 1'b0;
  end
  // Sets the resting level, used for falling-edge triggering.
  task automatic set_idle(input logic v);
    @(posedge clk_in);
    idle_lvl = v;
    line_out <= v;
  endtask
  // Drives the active level for w clock cycles, from a rising edge.
  task automatic pulse(input int w);
    @(posedge clk_in);
    line_out <= ~idle_lvl;
    repeat (w) @(posedge clk_in);
    line_out <= idle_lvl;
  endtask
endmodule // tes_trig_src

// *** testbench/trigger_exposure_sequencer_tb.sv ***
// Self-checking bench for the trigger and exposure sequencer.
// Assumes an APB slave; each transfer waits for pready under the watchdog.
`timescale 1ns/1ps
module trigger_exposure_sequencer_tb;
  logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in;
  logic [7:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out, external_fire_line_in;
  logic exposure_active_out, frame_start_out, trigger_wait_out;
  int n_fail = 0, comparisons = 0, nfs = 0, w, len, f0;
  // Cycles per microsecond given to the design, kept small for run time.
  localparam int unsigned US = 4;

  tes_sequencer #(
    .US_CYCLES(US)
  ) tes_sequencer_inst (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_out),
    .pready_out(pready_out),
    .pslverr_out(pslverr_out),
    .external_fire_line_in(external_fire_line_in),
    .exposure_active_out(exposure_active_out),
    .frame_start_out(frame_start_out),
    .trigger_wait_out(trigger_wait_out)
  );
  tes_trig_src tes_trig_src_inst (
    .clk_in(clk_in),
    .line_out(external_fire_line_in)
  );

  // Clock generator and watchdog.
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  initial begin
    #300_000;
    n_fail++;
    results();
  end
  // Counts every frame start seen.
  always @(negedge clk_in) if (frame_start_out === 1'b1) nfs++;

  task automatic results;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One APB transfer; only the watchdog ends a wait for pready.
  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk(e, xe);
  endtask
  // Waits for a frame start, then times the exposure.
  task automatic expo(input int lim);
    w = 0;
    len = 0;
    while (frame_start_out !== 1'b1 && w < lim) begin
      @(negedge clk_in);
      w++;
    end
    while (exposure_active_out === 1'b1) begin
      @(negedge clk_in);
      len++;
    end
  endtask
  task automatic wt_idle;
    int k;
    for (k = 0; k < 3000 && trigger_wait_out !== 1'b1; k++)
      @(negedge clk_in);
    chk(trigger_wait_out, 1'b1);
  endtask

  // Reset values, unmapped access and exposure clamping.
  task automatic s_reset;
    expo(10);
    chk(w <= 2, 1'b1);
    chk(len >= 5000 * US && len <= 5000 * US + 2, 1'b1);
    rd(tes_pkg::OFS_EXPOSURE, 32'h1388, 1'b0);
    rd(tes_pkg::OFS_BULK, 32'h0, 1'b0);
    rd(8'h40, 32'h0, 1'b1);
    wr(tes_pkg::OFS_EXPOSURE, 32'ha);
    rd(tes_pkg::OFS_EXPOSURE, 32'h1e, 1'b0);
    wr(tes_pkg::OFS_EXPOSURE, 32'h1000000);
    rd(tes_pkg::OFS_EXPOSURE, 32'hf42400, 1'b0);
    wr(tes_pkg::OFS_EXPOSURE, 32'h28);
    wr(tes_pkg::OFS_PACE, 32'h1e);
  endtask
  // Free run with level sequence chosen still times from exposure.
  task automatic s_free;
    wr(tes_pkg::OFS_CTRL, 32'h4);
    expo(30000);
    chk(len >= 40 * US && len <= 40 * US + 2, 1'b1);
  endtask
  // Hardware edge trigger, with a second edge inside the exposure.
  task automatic s_edge;
    wr(tes_pkg::OFS_CTRL, 32'h1);
    wt_idle();
    f0 = nfs;
    fork
      begin
        tes_trig_src_inst.pulse(20);
        repeat (50) @(posedge clk_in);
        tes_trig_src_inst.pulse(20);
      end
      expo(10);
    join
    chk(w <= 3, 1'b1);
    chk(len >= 40 * US && len <= 40 * US + 2, 1'b1);
    repeat (20) @(posedge clk_in);
    chk(nfs - f0, 1);
  endtask
  // Level sequence follows the pulse width.
  task automatic s_level;
    wr(tes_pkg::OFS_CTRL, 32'h5);
    wt_idle();
    fork
      tes_trig_src_inst.pulse(400);
      expo(10);
    join
    chk(len > 395 && len < 405, 1'b1);
  endtask
  // Bulk sequence gives the programmed frame count per trigger.
  task automatic s_bulk;
    wr(tes_pkg::OFS_BULK, 32'h3);
    wr(tes_pkg::OFS_CTRL, 32'h9);
    wt_idle();
    f0 = nfs;
    tes_trig_src_inst.pulse(20);
    repeat (700) @(posedge clk_in);
    chk(nfs - f0, 3);
  endtask
  // Falling edge polarity, then the edge-to-exposure delay.
  task automatic s_pol;
    wr(tes_pkg::OFS_CTRL, 32'h11);
    tes_trig_src_inst.set_idle(1'b1);
    wt_idle();
    fork
      tes_trig_src_inst.pulse(20);
      expo(10);
    join
    chk(w <= 3, 1'b1);
    wr(tes_pkg::OFS_DELAY, 32'h2);
    wt_idle();
    fork
      tes_trig_src_inst.pulse(20);
      expo(1000);
    join
    chk(w >= 2 * US && w <= 2 * US + 4, 1'b1);
  endtask
  // Software origin ignores the line and fires on a command write.
  task automatic s_soft;
    wr(tes_pkg::OFS_CTRL, 32'h13);
    wt_idle();
    f0 = nfs;
    tes_trig_src_inst.pulse(20);
    repeat (100) @(posedge clk_in);
    chk(nfs - f0, 0);
    wr(tes_pkg::OFS_FIRE, 32'h1);
    fork
      begin
        repeat (20) @(posedge clk_in);
        wr(tes_pkg::OFS_FIRE, 32'h1);
      end
      expo(300);
    join
    chk(nfs - f0, 1);
    repeat (20) @(posedge clk_in);
    chk(nfs - f0, 1);
  endtask
  // Unspecified policy takes the exposure length from the pace value.
  task automatic s_policy;
    wr(tes_pkg::OFS_PACE, 32'h32);
    wr(tes_pkg::OFS_CTRL, 32'h33);
    wt_idle();
    wr(tes_pkg::OFS_FIRE, 32'h1);
    expo(300);
    chk(len >= 50 * US && len <= 50 * US + 2, 1'b1);
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    sys_rst_in = 1'b1;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    s_reset();
    s_free();
    s_edge();
    s_level();
    s_bulk();
    s_pol();
    s_soft();
    s_policy();
    results();
  end
endmodule // trigger_exposure_sequencer_tb
